/* File: verification/host_to_panel_passthrough_test.sv */
`timescale 1ns/1ps
`default_nettype none
module host_to_panel_passthrough_test import hpp_pkg::*; ;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk_i = 1'h0;
  logic reset_i = 1'h1;
  hpp_host_t host;
  hpp_cfg_t cfg;
  logic [DOUT_W-1:0] own_pixel, content, pdata_i, pdo;
  logic own_valid, own_regsel, hdo_oe, own_ready, wr_n, rd_n, rs, pdo_oe;
  logic [HOST_W-1:0] hdo;
  logic [PANEL_CNT-1:0] sel_n;
  int mismatches = 0;
  int checks_done = 0;

  always #2.5 clk_i = ~clk_i;

  hpp_passthrough DUT (.clk_i(clk_i), .reset_i(reset_i), .host_i(host),
    .host_panel_data_o(hdo), .host_panel_data_oe_o(hdo_oe), .cfg_i(cfg),
    .own_pixel_i(own_pixel), .own_valid_i(own_valid), .own_regsel_i(own_regsel),
    .own_ready_o(own_ready), .panel_select_n_o(sel_n), .panel_write_n_o(wr_n),
    .panel_read_n_o(rd_n), .panel_regsel_o(rs), .panel_data_o(pdo),
    .panel_data_oe_o(pdo_oe), .panel_data_i(pdata_i));

  hpp_panel_model PANEL (.select_n_i(sel_n), .read_n_i(rd_n), .oe_i(pdo_oe),
    .content_i(content), .data_o(pdata_i));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [DOUT_W-1:0] got, input logic [DOUT_W-1:0] exp,
                     input string msg);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk

  // host owns the sequence; every change lands mid-cycle
  task automatic set_host(input logic cs, input logic a, input logic b, input logic r,
                          input logic [HOST_W-1:0] d);
    @(negedge clk_i);
    host = '{panel_cs_n: cs, strobe_a_n: a, strobe_b_n: b, host_panel_regsel: r,
             host_panel_data: d};
    #1;
  endtask : set_host

  function automatic logic [DOUT_W-1:0] exp_wr(input int k, input logic [HOST_W-1:0] d);
    case (k)
      0: return {d[15:11], d[15], d[10:5], d[4:0], d[4]};
      1: return {d[15:8], d[8], d[7:0], 1'h0};
      2: return {1'h0, d[15:9], d[8], d[8], d[7:0]};
      3: return {d[15:8], 1'h0, d[7:0], 1'h0};
      4: return {9'h000, d[8:0]};
      default: return {9'h000, d[7:0], 1'h0};
    endcase
  endfunction : exp_wr

  function automatic logic [HOST_W-1:0] exp_rd(input int k, input logic [DOUT_W-1:0] b);
    case (k)
      0: return {b[17:13], b[11:6], b[5:1]};
      2: return {b[16:10], b[9], b[7:0]};
      4: return {7'h00, b[8:0]};
      5: return {8'h00, b[8:1]};
      default: return {b[17:10], b[8:1]};
    endcase
  endfunction : exp_rd

  // case k: 0 pixel18, 1 cmd ver1, 2 cmd ver2, 3 w16, 4 w9, 5 w8
  task automatic set_case(input int k, input logic m);
    @(negedge clk_i);
    cfg = '{width: (k < 3) ? HPP_W18 : hpp_width_t'(k - 2), cmd_ver2: (k == 2),
            rw_enable_mode: m, panel_pick: k[0]};
  endtask : set_case

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_idle();
    for (int m = 0; m < 2; m++) begin
      set_case(0, m[0]);
      set_host(1'h0, 1'h1, m[0] ? 1'h0 : 1'h1, 1'h0, 16'hA5A5);
      chk({17'h0, wr_n}, 18'h1, "idle write strobe");
      chk({17'h0, rd_n}, 18'h1, "idle read strobe");
      chk({16'h0, pdo_oe, hdo_oe}, 18'h0, "idle drive");
      chk({17'h0, rs}, 18'h0, "host regsel low");
      chk({16'h0, sel_n}, 18'h2, "select held");
      set_host(1'h0, 1'h1, 1'h1, 1'h1, 16'hA5A5);
      chk({17'h0, rs}, 18'h1, "host regsel high");
    end
    $display("test idle done");
  endtask : t_idle

  task automatic t_access(input logic wr);
    logic [HOST_W-1:0] d;
    logic [PANEL_CNT-1:0] es;
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 6; k++) begin
        set_case(k, m[0]);
        d = k[0] ? 16'h49E6 : 16'hB6D9;
        if (k == 4) d = d & 16'h01FF;
        if (k == 5) d = d & 16'h00FF;
        content = k[0] ? 18'h2D5A6 : 18'h1A659;
        es = k[0] ? 2'h1 : 2'h2;
        set_host(1'h0, m[0] ? 1'h0 : ~wr, m[0] ? ~wr : wr, (k == 0), d);
        chk({16'h0, sel_n}, {16'h0, es}, "panel select");
        chk({16'h0, wr_n, rd_n}, wr ? 18'h1 : 18'h2, "strobes");
        if (wr) begin
          chk({17'h0, pdo_oe}, 18'h1, "bus driven");
          chk(pdo, exp_wr(k, d), "write map");
        end else begin
          chk({16'h0, pdo_oe, hdo_oe}, 18'h1, "read drive");
          chk({2'h0, hdo}, {2'h0, exp_rd(k, content)}, "read map");
        end
        set_host(1'h0, 1'h1, 1'h1, 1'h1, d);
        chk({17'h0, pdo_oe}, 18'h0, "bus released");
      end
    end
    chk({17'h0, own_ready}, 18'h0, "engine held off");
    $display("test access done");
  endtask : t_access

  task automatic t_own();
    logic [DOUT_W-1:0] hi, lo;
    set_host(1'h1, 1'h1, 1'h1, 1'h1, 16'h0000);
    for (int k = 2; k < 6; k++) begin
      set_case(k, 1'h0);
      own_pixel = 18'h2B3C5;
      own_regsel = k[0];
      hi = (k == 4) ? {9'h000, own_pixel[17:9]} : {9'h000, own_pixel[15:8], 1'h0};
      lo = (k == 4) ? {9'h000, own_pixel[8:0]} : {9'h000, own_pixel[7:0], 1'h0};
      if (k == 2) hi = own_pixel;
      if (k == 3) hi = {own_pixel[15:8], 1'h0, own_pixel[7:0], 1'h0};
      if (k < 4) lo = hi;
      // one edge so the registered regsel has taken the new value
      @(negedge clk_i);
      for (int i = 0; i < 20 && own_ready !== 1'h1; i++) @(negedge clk_i);
      chk({17'h0, own_ready}, 18'h1, "engine ready");
      chk({17'h0, rs}, {17'h0, own_regsel}, "own regsel");
      own_valid = 1'h1;
      @(negedge clk_i);
      own_valid = 1'h0;
      for (int i = 0; i < 3 && wr_n !== 1'h0; i++) @(negedge clk_i);
      chk(pdo, hi, "first transfer");
      chk({16'h0, sel_n}, {16'h0, k[0] ? 2'h1 : 2'h2}, "own select");
      @(negedge clk_i);
      chk({17'h0, wr_n}, 18'h1, "hold phase");
      @(negedge clk_i);
      chk({17'h0, wr_n}, (k < 4) ? 18'h1 : 18'h0, "second strobe");
      chk(pdo, lo, "second transfer");
      repeat (3) @(negedge clk_i);
      chk({15'h0, sel_n, pdo_oe}, 18'h6, "engine idle");
      chk({17'h0, rd_n}, 18'h1, "no own read");
    end
    $display("test own done");
  endtask : t_own

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    host = '{panel_cs_n: 1'h1, strobe_a_n: 1'h1, strobe_b_n: 1'h1, host_panel_regsel: 1'h1,
             host_panel_data: 16'h0000};
    cfg = '{width: HPP_W18, cmd_ver2: 1'h0, rw_enable_mode: 1'h0, panel_pick: 1'h0};
    own_pixel = 18'h00000;
    own_valid = 1'h0;
    own_regsel = 1'h1;
    content = 18'h00000;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'h0;
    t_idle();
    t_access(1'h1);
    t_access(1'h0);
    t_own();
    wrap_up();
  end

  // whole run is well under two hundred cycles
  initial begin
    #20000;
    mismatches++;
    wrap_up();
  end
endmodule : host_to_panel_passthrough_test
`default_nettype wire

/* File: verification/hpp_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hpp_panel_model import hpp_pkg::*; (
  // panel control pins
  input wire logic [PANEL_CNT-1:0] select_n_i,
  input wire logic read_n_i,
  input wire logic oe_i,
  // content the panel returns
  input wire logic [DOUT_W-1:0] content_i,
  // panel data pins
  output logic [DOUT_W-1:0] data_o
);
  // ---------------------------------------------------------------
  // read response
  // ---------------------------------------------------------------
  // released bus shows the inverse, so a stale value never matches
  logic drive;
  assign drive = (~&select_n_i) & ~read_n_i & ~oe_i;
  assign data_o = drive ? content_i : ~content_i;
endmodule : hpp_panel_model
`default_nettype wire

/* File: verilog/hpp_passthrough.sv */
// Functional notes
// - host panel pins pass through combinationally
// - panel pick input selects target panel
// - selected panel chip-select asserted on read
// - host write drives mapped word onto bus
// - host read returns mapped bus to host
// - own logic drives regsel when host away
// - 18-bit pixel: 565 expanded to 666
// - 18-bit command: two selectable word placements
// - 16-bit: word on bits 17:10, 8:1
// - 9-bit: own pixel in two transfers
// - 8-bit: own pixel two transfers on 8:1
`timescale 1ns/1ps
`default_nettype none
module hpp_passthrough import hpp_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // host panel pins
  input wire hpp_host_t host_i,
  output logic [HOST_W-1:0] host_panel_data_o,
  output logic host_panel_data_oe_o,
  // configuration from the control unit
  input wire hpp_cfg_t cfg_i,
  // device own pixel stream
  input wire logic [DOUT_W-1:0] own_pixel_i,
  input wire logic own_valid_i,
  input wire logic own_regsel_i,
  output logic own_ready_o,
  // panel pins
  output logic [PANEL_CNT-1:0] panel_select_n_o,
  output logic panel_write_n_o,
  output logic panel_read_n_o,
  output logic panel_regsel_o,
  output logic [DOUT_W-1:0] panel_data_o,
  output logic panel_data_oe_o,
  input wire logic [DOUT_W-1:0] panel_data_i
);

  // ---------------------------------------------------------------
  // host strobe decode
  // ---------------------------------------------------------------
  // no clock anywhere on this path so it survives a stopped clock
  wire host_act = ~host_i.panel_cs_n;
  wire sep_wr = ~host_i.strobe_a_n & host_i.strobe_b_n;
  wire sep_rd = host_i.strobe_a_n & ~host_i.strobe_b_n;
  wire rwe_wr = ~host_i.strobe_a_n & ~host_i.strobe_b_n;
  wire rwe_rd = ~host_i.strobe_a_n & host_i.strobe_b_n;
  wire host_wr = host_act & (cfg_i.rw_enable_mode ? rwe_wr : sep_wr);
  wire host_rd = host_act & (cfg_i.rw_enable_mode ? rwe_rd : sep_rd);
  wire host_pixel = host_i.host_panel_regsel;

  // ---------------------------------------------------------------
  // panel chip-select decode
  // ---------------------------------------------------------------
  wire [PANEL_CNT-1:0] pick_n;
  genvar gi;
  generate
    for (gi = 0; gi < PANEL_CNT; gi = gi + 1) begin : g_pick
      assign pick_n[gi] = (cfg_i.panel_pick != 1'(gi));
    end
  endgenerate

  // ---------------------------------------------------------------
  // data layout mapping
  // ---------------------------------------------------------------
  wire [DOUT_W-1:0] wr_word;
  wire [HOST_W-1:0] rd_word;

  // pixel expansion and command placement live in the mapper
  hpp_wr_map u_wr_map (
    .word_i(host_i.host_panel_data),
    .pixel_i(host_pixel),
    .cfg_i(cfg_i),
    .dout_o(wr_word)
  );

  hpp_rd_map u_rd_map (
    .din_i(panel_data_i),
    .pixel_i(host_pixel),
    .cfg_i(cfg_i),
    .word_o(rd_word)
  );

  // ---------------------------------------------------------------
  // host chip-select synchroniser
  // ---------------------------------------------------------------
  logic [SYNC_STAGES-1:0] cs_sync_q;
  logic host_free_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cs_sync_q <= '1;
    end else begin
      cs_sync_q <= {cs_sync_q[SYNC_STAGES-2:0], host_i.panel_cs_n};
    end
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      host_free_q <= 1'h0;
    end else if (cs_sync_q[1] == cs_sync_q[2]) begin
      host_free_q <= cs_sync_q[2];
    end
  end

  // ---------------------------------------------------------------
  // own transfer engine
  // ---------------------------------------------------------------
  hpp_state_t state_q, state_d;
  logic [DOUT_W-1:0] pix_q;
  logic ready_q;
  logic own_wr_n_q;
  logic own_oe_q;
  logic own_regsel_q;
  logic [PANEL_CNT-1:0] own_cs_n_q;
  logic [DOUT_W-1:0] own_dout_q;

  wire two_xfer = (cfg_i.width == HPP_W9) | (cfg_i.width == HPP_W8);
  wire take = own_valid_i & ready_q;
  wire [DOUT_W-1:0] pix_d = take ? own_pixel_i : pix_q;
  wire first_d = (state_d == ST_W1) | (state_d == ST_H1);
  wire wr_d = (state_d == ST_W1) | (state_d == ST_W2);
  wire [8:0] half9 = first_d ? pix_d[17:9] : pix_d[8:0];
  wire [7:0] half8 = first_d ? pix_d[15:8] : pix_d[7:0];
  wire [DOUT_W-1:0] own16 = {pix_d[15:8], 1'h0, pix_d[7:0], 1'h0};
  wire [DOUT_W-1:0] own_word_d =
    (cfg_i.width == HPP_W18) ? pix_d :
    (cfg_i.width == HPP_W16) ? own16 :
    (cfg_i.width == HPP_W9) ? {9'h000, half9} : {9'h000, half8, 1'h0};

  // each transfer is a write-low cycle then a write-high cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_W1;
        end
      end
      ST_W1: begin
        state_d = ST_H1;
      end
      ST_H1: begin
        state_d = two_xfer ? ST_W2 : ST_IDLE;
      end
      ST_W2: begin
        state_d = ST_H2;
      end
      ST_H2: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // a host access mid-transfer overrides the pins; the engine runs on
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      pix_q <= DOUT_RST;
      ready_q <= 1'h0;
    end else begin
      state_q <= state_d;
      pix_q <= pix_d;
      ready_q <= (state_d == ST_IDLE) & host_free_q;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      own_wr_n_q <= STROBE_N_RST;
      own_oe_q <= 1'h0;
      own_regsel_q <= REGSEL_RST;
      own_cs_n_q <= SEL_N_RST;
      own_dout_q <= DOUT_RST;
    end else begin
      own_wr_n_q <= ~wr_d;
      own_oe_q <= (state_d != ST_IDLE);
      own_regsel_q <= own_regsel_i;
      own_cs_n_q <= (state_d != ST_IDLE) ? pick_n : SEL_N_RST;
      own_dout_q <= own_word_d;
    end
  end

  assign own_ready_o = ready_q;

  // ---------------------------------------------------------------
  // pin multiplexing
  // ---------------------------------------------------------------
  assign panel_select_n_o = host_act ? pick_n : own_cs_n_q;
  assign panel_write_n_o = host_act ? ~host_wr : own_wr_n_q;
  assign panel_read_n_o = host_act ? ~host_rd : STROBE_N_RST;
  assign panel_regsel_o = host_act ? host_i.host_panel_regsel : own_regsel_q;
  assign panel_data_o = host_act ? wr_word : own_dout_q;
  assign panel_data_oe_o = host_act ? host_wr : own_oe_q;
  assign host_panel_data_o = rd_word;
  assign host_panel_data_oe_o = host_rd;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_route_strobes: assert property (@(posedge clk_i) disable iff (reset_i)
    host_act |-> (panel_write_n_o == ~host_wr) && (panel_read_n_o == ~host_rd)
                 && (panel_regsel_o == host_i.host_panel_regsel))
    else $error("host strobes not routed to panel");

  chk_panel_pick: assert property (@(posedge clk_i) disable iff (reset_i)
    host_act |-> (panel_select_n_o[cfg_i.panel_pick] == 1'b0)
                 && ($countones(panel_select_n_o) == PANEL_CNT - 1))
    else $error("wrong panel selected");

  chk_read_select: assert property (@(posedge clk_i) disable iff (reset_i)
    host_rd |-> !panel_select_n_o[cfg_i.panel_pick] && !panel_read_n_o && panel_write_n_o)
    else $error("read without panel select");

  chk_write_drive: assert property (@(posedge clk_i) disable iff (reset_i)
    host_wr |-> panel_data_oe_o && !host_panel_data_oe_o && (panel_data_o == wr_word))
    else $error("host write not driven on panel bus");

  chk_read_return: assert property (@(posedge clk_i) disable iff (reset_i)
    host_rd |-> !panel_data_oe_o && host_panel_data_oe_o && (host_panel_data_o == rd_word))
    else $error("host read not returned");

  chk_idle_float: assert property (@(posedge clk_i) disable iff (reset_i)
    (host_act && host_i.strobe_a_n && host_i.strobe_b_n) |->
      panel_write_n_o && panel_read_n_o && !panel_data_oe_o && !host_panel_data_oe_o)
    else $error("panel bus not idle while host idle");

  chk_own_regsel: assert property (@(posedge clk_i) disable iff (reset_i)
    (!host_act && $past(!reset_i)) |-> (panel_regsel_o == $past(own_regsel_i)))
    else $error("own regsel not driven");

  chk_pixel_expand: assert property (@(posedge clk_i) disable iff (reset_i)
    (host_wr && host_pixel && cfg_i.width == HPP_W18) |->
      (panel_data_o[RED_LSB_POS] == host_i.host_panel_data[15])
      && (panel_data_o[BLUE_LSB_POS] == host_i.host_panel_data[4])
      && (panel_data_o[TOP_POS:RED_LSB_POS+1] == host_i.host_panel_data[15:11]))
    else $error("565 to 666 expansion wrong");

  chk_cmd_map: assert property (@(posedge clk_i) disable iff (reset_i)
    (host_wr && !host_pixel && cfg_i.width == HPP_W18) |->
      (cfg_i.cmd_ver2 ? (!panel_data_o[TOP_POS]
                         && panel_data_o[7:0] == host_i.host_panel_data[7:0])
                      : (!panel_data_o[0]
                         && panel_data_o[TOP_POS:10] == host_i.host_panel_data[15:8])))
    else $error("command placement wrong");

  chk_w16_map: assert property (@(posedge clk_i) disable iff (reset_i)
    (host_wr && cfg_i.width == HPP_W16) |->
      (panel_data_o[TOP_POS:10] == host_i.host_panel_data[15:8])
      && (panel_data_o[8:1] == host_i.host_panel_data[7:0]))
    else $error("16-bit placement wrong");

  chk_two_halves: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_H1 && two_xfer) |->
      ##1 (state_q == ST_W2 && !own_wr_n_q) ##1 (state_q == ST_H2) ##1 (state_q == ST_IDLE))
    else $error("second transfer missing");

  chk_nine_first: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_W1 && cfg_i.width == HPP_W9) |->
      (own_dout_q[8:0] == pix_q[17:9]) && (own_dout_q[TOP_POS:9] == 9'h000))
    else $error("9-bit first half wrong");

  chk_rw_decode: assert property (@(posedge clk_i) disable iff (reset_i)
    (host_act && cfg_i.rw_enable_mode && !host_i.strobe_a_n) |->
      (host_i.strobe_b_n ? (!panel_read_n_o && panel_write_n_o && host_panel_data_oe_o)
                         : (!panel_write_n_o && panel_read_n_o && panel_data_oe_o)))
    else $error("rw-enable decode wrong");

  chk_busy_refuse: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q != ST_IDLE) |-> !own_ready_o)
    else $error("engine ready while busy");

  chk_host_holdoff: assert property (@(posedge clk_i) disable iff (reset_i)
    !$past(host_free_q) |-> !own_ready_o)
    else $error("engine ready while host holds panel");

  chk_own_drive: assert property (@(posedge clk_i) disable iff (reset_i)
    (!host_act && state_q != ST_IDLE) |->
      panel_data_oe_o && panel_read_n_o && !panel_select_n_o[cfg_i.panel_pick])
    else $error("own transfer not driven to picked panel");

  chk_own_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    (!host_act && state_q == ST_IDLE) |->
      panel_write_n_o && panel_read_n_o && !panel_data_oe_o && (panel_select_n_o == SEL_N_RST))
    else $error("panel pins not idle");

  chk_eight_first: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_W1 && cfg_i.width == HPP_W8) |->
      (own_dout_q == {9'h000, pix_q[15:8], 1'h0}))
    else $error("8-bit first half wrong");

  chk_nine_second: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_W2 && cfg_i.width == HPP_W9) |->
      (own_dout_q[8:0] == pix_q[8:0]))
    else $error("9-bit second half wrong");

endmodule : hpp_passthrough
`default_nettype wire

/* File: verilog/hpp_pkg.sv */
`default_nettype none
package hpp_pkg;

  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int HOST_W = 16;
  localparam int DOUT_W = 18;
  localparam int PANEL_CNT = 2;
  localparam int SYNC_STAGES = 3;

  // ---------------------------------------------------------------
  // field positions on the panel bus
  // ---------------------------------------------------------------
  localparam int RED_LSB_POS = 12;
  localparam int BLUE_LSB_POS = 0;
  localparam int GAP16_POS = 9;
  localparam int TOP_POS = 17;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DOUT_W-1:0] DOUT_RST = 18'h00000;
  localparam logic [PANEL_CNT-1:0] SEL_N_RST = 2'h3;
  localparam logic STROBE_N_RST = 1'h1;
  localparam logic REGSEL_RST = 1'h1;

  // ---------------------------------------------------------------
  // modes and states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HPP_W18 = 2'h0,
    HPP_W16 = 2'h1,
    HPP_W9 = 2'h2,
    HPP_W8 = 2'h3
  } hpp_width_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_W1 = 3'h1,
    ST_H1 = 3'h3,
    ST_W2 = 3'h2,
    ST_H2 = 3'h6
  } hpp_state_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic panel_cs_n;
    logic strobe_a_n;
    logic strobe_b_n;
    logic host_panel_regsel;
    logic [HOST_W-1:0] host_panel_data;
  } hpp_host_t;

  typedef struct packed {
    hpp_width_t width;
    logic cmd_ver2;
    logic rw_enable_mode;
    logic panel_pick;
  } hpp_cfg_t;

endpackage : hpp_pkg
`default_nettype wire

/* File: verilog/hpp_rd_map.sv */
`timescale 1ns/1ps
`default_nettype none
module hpp_rd_map import hpp_pkg::*; (
  // panel side
  input wire logic [DOUT_W-1:0] din_i,
  input wire logic pixel_i,
  input wire hpp_cfg_t cfg_i,
  // host side
  output logic [HOST_W-1:0] word_o
);

  // inverse of the write layouts; duplicated copy bits are dropped
  wire [HOST_W-1:0] pix = {din_i[17:13], din_i[11:6], din_i[5:1]};
  wire [HOST_W-1:0] cmd1 = {din_i[17:10], din_i[8:1]};
  wire [HOST_W-1:0] cmd2 = {din_i[16:10], din_i[9], din_i[7:0]};
  wire [HOST_W-1:0] r16 = {din_i[17:10], din_i[8:1]};
  wire [HOST_W-1:0] r9 = {7'h00, din_i[8:0]};
  wire [HOST_W-1:0] r8 = {8'h00, din_i[8:1]};
  wire [HOST_W-1:0] r18 = pixel_i ? pix : (cfg_i.cmd_ver2 ? cmd2 : cmd1);

  assign word_o = (cfg_i.width == HPP_W18) ? r18 :
                  (cfg_i.width == HPP_W16) ? r16 :
                  (cfg_i.width == HPP_W9) ? r9 : r8;

endmodule : hpp_rd_map
`default_nettype wire

/* File: verilog/hpp_wr_map.sv */
`timescale 1ns/1ps
`default_nettype none
module hpp_wr_map import hpp_pkg::*; (
  // host side
  input wire logic [HOST_W-1:0] word_i,
  input wire logic pixel_i,
  input wire hpp_cfg_t cfg_i,
  // panel side
  output logic [DOUT_W-1:0] dout_o
);

  wire [DOUT_W-1:0] pix18 =
    {word_i[15:11], word_i[15], word_i[10:5], word_i[4:0], word_i[4]};
  wire [DOUT_W-1:0] cmd1 = {word_i[15:8], word_i[8], word_i[7:0], 1'h0};
  wire [DOUT_W-1:0] cmd2 = {1'h0, word_i[15:9], word_i[8], word_i[8], word_i[7:0]};
  wire [DOUT_W-1:0] w16 = {word_i[15:8], 1'h0, word_i[7:0], 1'h0};
  wire [DOUT_W-1:0] w9 = {9'h000, word_i[8:0]};
  wire [DOUT_W-1:0] w8 = {9'h000, word_i[7:0], 1'h0};
  wire [DOUT_W-1:0] w18 = pixel_i ? pix18 : (cfg_i.cmd_ver2 ? cmd2 : cmd1);

  assign dout_o = (cfg_i.width == HPP_W18) ? w18 :
                  (cfg_i.width == HPP_W16) ? w16 :
                  (cfg_i.width == HPP_W9) ? w9 : w8;

endmodule : hpp_wr_map
`default_nettype wire
